//--- spms_top.sv
// Byte-wide serial port, master or slave, behind a simple register port.
// Assumes pin inputs synchronous to clk_i and an external pad resolver.
//
// Summary of operation
// - Slave with select high is passive and drops partial bits at once.
// - Slave select is an input; low activates, MISO drives if enabled.
// - Master with select as output: select pin is plain output.
// - Master with select input low drops to slave, MOSI and SCK released.
// - That drop also sets the completion flag, raising the interrupt.
// - Interrupt enable bit 7 gates the completion flag to the request.
// - Port enable bit 6 must be one for any transfer.
// - Bit order bit 5: one sends LSB first, zero MSB first.
// - Master select bit 4: one master, zero slave.
// - Polarity bit 3 sets SCK idle level and edge directions.
// - Phase bit 2: zero samples leading edge, one samples trailing.
// - Rate bits divide clock by 4,16,64,128 or 2,8,32,64 doubled.
// - Completion flag bit 7 sets per byte; clears by ack or read then access.
// - Collision flag bit 6 sets on data write mid-transfer; clears only by read then access.
// - Status bits 5 to 1 read as zero.
// - Double rate bit 0 doubles master SCK, shortest period two clocks.
// - Data write starts a transfer in master mode; data read returns receive buffer.
// - Shift and sample on opposite edges; modes 0 to 3 are polarity,phase.
// - Master write runs SCK for eight bits, stops, sets completion flag.
// - Transmit single buffered; receive buffer held until next byte.
// - When enabled, mode gates pin directions; each output also needs its pdir bit set.
//
// Implementation choices: the plain strobed port and the register addresses.
`timescale 1ns/10ps
`include "spms_defs.svh"
module spms_top
  import spms_pkg::*;
#(
  parameter int DATA_W = 8,
  parameter int DIV_W  = 6
)
(
  input  wire logic              clk_i,
  input  wire logic              arst_n_i,
  input  wire logic [2:0]        reg_addr_i,
  input  wire logic [DATA_W-1:0] reg_wdata_i,
  input  wire logic              reg_we_i,
  input  wire logic              reg_re_i,
  output logic      [DATA_W-1:0] reg_rdata_o,
  input  wire logic              global_irq_en_i,
  input  wire logic              irq_ack_i,
  output logic                   irq_o,
  input  wire logic              sck_i,
  output logic                   sck_o,
  output logic                   sck_oe_n_o,
  input  wire logic              mosi_i,
  output logic                   mosi_o,
  output logic                   mosi_oe_n_o,
  input  wire logic              miso_i,
  output logic                   miso_o,
  output logic                   miso_oe_n_o,
  input  wire logic              ss_n_i,
  output logic                   ss_n_o,
  output logic                   ss_oe_n_o
);
  // ****************************************
  // Declarations
  // ****************************************
  logic              irq_en;
  logic              port_en;
  logic              lsb_first;
  logic              master_select;
  logic              clock_idle_level;
  logic              clock_edge_phase;
  logic [1:0]        rate;
  logic              double_rate;
  logic [4:0]        pdir;
  logic              tcf;
  logic              write_collision_flag;
  logic              arm_tcf;
  logic              arm_write_collision_flag;
  spms_state_t       state;
  logic [DATA_W-1:0] sh;
  logic [DATA_W-1:0] next_sh;
  logic [DATA_W-1:0] rx_buf;
  logic              out_bit;
  logic              sck_q;
  logic [3:0]        edge_cnt;
  logic [2:0]        bit_cnt;
  logic              slv_busy;
  logic              wr_ctrl;
  logic              wr_stat;
  logic              wr_data;
  logic              wr_pdir;
  logic              rd_stat;
  logic              rd_data;
  logic              data_acc;
  logic              en_m;
  logic              en_s;
  logic              mode_fault;
  logic              slave_act;
  logic              master_run;
  logic              m_tick;
  logic              is_lead;
  logic              is_trail;
  logic              sample;
  logic              setup;
  logic              rx_in;
  logic              busy;
  logic              start;
  logic              master_end;
  logic              slave_end;
  logic              xfer_end;
  spms_edge_if       eif ();

  if (DATA_W != 8)
  begin : g_bad_width
    $error("spms_top: DATA_W must be 8");
  end

  // ****************************************
  // Decode and shared terms
  // ****************************************
  assign wr_ctrl  = reg_we_i && (reg_addr_i == `SPMS_OFF_CTRL);
  assign wr_stat  = reg_we_i && (reg_addr_i == `SPMS_OFF_STAT);
  assign wr_data  = reg_we_i && (reg_addr_i == `SPMS_OFF_DATA);
  assign wr_pdir  = reg_we_i && (reg_addr_i == `SPMS_OFF_PDIR);
  assign rd_stat  = reg_re_i && (reg_addr_i == `SPMS_OFF_STAT);
  assign rd_data  = reg_re_i && (reg_addr_i == `SPMS_OFF_DATA);
  assign data_acc = wr_data || rd_data;

  assign en_m       = port_en && master_select;
  assign en_s       = port_en && !master_select;
  assign mode_fault = en_m && !pdir[`SPMS_PDIR_SS] && !ss_n_i;
  assign slave_act  = en_s && !ss_n_i;
  assign master_run = en_m && (state == SPMS_SHIFT);

  assign eif.sck  = sck_i;
  assign eif.clock_idle_level = clock_idle_level;

  spms_edge_det u_edge
  (
    .clk_i    (clk_i),
    .arst_n_i (arst_n_i),
    .eif      (eif)
  );

  spms_rate_div #(.CNT_W (DIV_W)) u_div
  (
    .clk_i    (clk_i),
    .arst_n_i (arst_n_i),
    .run_i    (master_run),
    .limit_i  (DIV_W'(spms_half_limit({double_rate, rate}))),
    .tick_o   (m_tick)
  );

  // Even edge counts are leading edges of the master clock
  assign is_lead  = master_run ? (m_tick && !edge_cnt[0])
                               : (slave_act && eif.lead);
  assign is_trail = master_run ? (m_tick && edge_cnt[0])
                               : (slave_act && eif.trail);
  assign sample   = clock_edge_phase ? is_trail : is_lead;
  assign setup    = clock_edge_phase ? is_lead : is_trail;
  assign rx_in    = master_select ? miso_i : mosi_i;
  assign next_sh  = lsb_first ? {rx_in, sh[DATA_W-1:1]}
                              : {sh[DATA_W-2:0], rx_in};

  assign busy       = (state == SPMS_SHIFT) || slv_busy;
  assign start      = wr_data && en_m && !busy;
  assign master_end = master_run && m_tick
                      && (edge_cnt == `SPMS_EDGES_LAST);
  assign slave_end  = slave_act && sample
                      && (bit_cnt == `SPMS_BITS_LAST);
  assign xfer_end   = master_end || slave_end;

  // ****************************************
  // Control, status extras and pin directions
  // ****************************************
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      {irq_en, port_en, lsb_first, master_select,
       clock_idle_level, clock_edge_phase, rate} <= `SPMS_RST_CTRL;
    end
    else if (wr_ctrl)
    begin
      irq_en        <= reg_wdata_i[`SPMS_CTRL_IRQEN];
      port_en       <= reg_wdata_i[`SPMS_CTRL_EN];
      lsb_first     <= reg_wdata_i[`SPMS_CTRL_LSBF];
      // Hardware drop to slave wins over a same-cycle write
      master_select <= reg_wdata_i[`SPMS_CTRL_MASTER_SELECT] && !mode_fault;
      clock_idle_level          <= reg_wdata_i[`SPMS_CTRL_CLOCK_IDLE_LEVEL];
      clock_edge_phase          <= reg_wdata_i[`SPMS_CTRL_CLOCK_EDGE_PHASE];
      rate          <= reg_wdata_i[`SPMS_CTRL_RATE_H:`SPMS_CTRL_RATE_L];
    end
    else if (mode_fault)
    begin
      master_select <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      double_rate <= 1'b0;
    else if (wr_stat)
      double_rate <= reg_wdata_i[`SPMS_STAT_DBL];
  end

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      pdir   <= `SPMS_RST_PDIR;
      ss_n_o <= `SPMS_RST_SSLVL;
    end
    else if (wr_pdir)
    begin
      pdir   <= reg_wdata_i[4:0];
      ss_n_o <= reg_wdata_i[`SPMS_PDIR_SSLVL];
    end
  end

  // ****************************************
  // Flags: a set wins over a clear
  // ****************************************
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      tcf      <= 1'b0;
      write_collision_flag     <= 1'b0;
      arm_tcf  <= 1'b0;
      arm_write_collision_flag <= 1'b0;
    end
    else
    begin
      tcf  <= xfer_end || mode_fault
              || (tcf && !irq_ack_i
                  && !(data_acc && (arm_tcf || arm_write_collision_flag)));
      write_collision_flag <= (wr_data && busy)
              || (write_collision_flag && !(data_acc && arm_write_collision_flag));
      if (rd_stat)
      begin
        arm_tcf  <= tcf;
        arm_write_collision_flag <= write_collision_flag;
      end
      else if (data_acc)
      begin
        arm_tcf  <= 1'b0;
        arm_write_collision_flag <= 1'b0;
      end
    end
  end

  // ****************************************
  // Master sequencer
  // ****************************************
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      state <= SPMS_IDLE;
    else if (!en_m || mode_fault)
      state <= SPMS_IDLE;
    else
    begin
      case (state)
        SPMS_IDLE:  state <= start ? SPMS_SHIFT : SPMS_IDLE;
        SPMS_SHIFT: state <= master_end ? SPMS_DONE : SPMS_SHIFT;
        SPMS_DONE:  state <= start ? SPMS_SHIFT : SPMS_IDLE;
        default:    state <= SPMS_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      edge_cnt <= 4'h0;
    else if (state != SPMS_SHIFT)
      edge_cnt <= 4'h0;
    else if (m_tick)
      edge_cnt <= edge_cnt + 4'h1;
  end

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      sck_q <= 1'b0;
    else if (state != SPMS_SHIFT)
      sck_q <= clock_idle_level;
    else if (m_tick)
      sck_q <= !sck_q;
  end

  // ****************************************
  // Shift path, shared by master and slave
  // ****************************************
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      sh      <= `SPMS_RST_DATA;
      out_bit <= 1'b0;
    end
    else if (wr_data && !busy)
    begin
      sh      <= reg_wdata_i;
      out_bit <= lsb_first ? reg_wdata_i[0] : reg_wdata_i[DATA_W-1];
    end
    else if (sample)
      sh <= next_sh;
    else if (setup)
      out_bit <= lsb_first ? sh[0] : sh[DATA_W-1];
  end

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      bit_cnt <= 3'h0;
    else if (start || mode_fault || !(master_run || slave_act))
      bit_cnt <= 3'h0;
    else if (sample)
      bit_cnt <= bit_cnt + 3'h1;
  end

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      slv_busy <= 1'b0;
    else if (!slave_act || slave_end)
      slv_busy <= 1'b0;
    else if (eif.lead)
      slv_busy <= 1'b1;
  end

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      rx_buf <= `SPMS_RST_DATA;
    else if (sample && (bit_cnt == `SPMS_BITS_LAST))
      rx_buf <= next_sh;
  end

  // ****************************************
  // Read port, data one cycle after the strobe
  // ****************************************
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      reg_rdata_o <= '0;
    else if (!reg_re_i)
      reg_rdata_o <= '0;
    else
    begin
      case (reg_addr_i)
        `SPMS_OFF_CTRL: reg_rdata_o <= {irq_en, port_en, lsb_first,
                                        master_select, clock_idle_level, clock_edge_phase, rate};
        `SPMS_OFF_STAT: reg_rdata_o <= {tcf, write_collision_flag, 5'h00,
                                        double_rate};
        `SPMS_OFF_DATA: reg_rdata_o <= rx_buf;
        `SPMS_OFF_PDIR: reg_rdata_o <= {3'h0, ss_n_o, pdir[3:0]};
        default:        reg_rdata_o <= '0;
      endcase
    end
  end

  // ****************************************
  // Pins and interrupt
  // ****************************************
  assign sck_o       = sck_q;
  assign mosi_o      = out_bit;
  assign miso_o      = out_bit;
  assign sck_oe_n_o  = !(en_m && pdir[`SPMS_PDIR_SCK]);
  assign mosi_oe_n_o = !(en_m && pdir[`SPMS_PDIR_MOSI]);
  assign miso_oe_n_o = !(slave_act && pdir[`SPMS_PDIR_MISO]);
  assign ss_oe_n_o   = !(pdir[`SPMS_PDIR_SS] && !en_s);
  assign irq_o       = tcf && irq_en && global_irq_en_i;

  // ****************************************
  // Checks
  // ****************************************
  chk_slave_idle_reset: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    (en_s && ss_n_i) |=> (bit_cnt == 3'h0) && !slv_busy)
    else $error("slave logic not reset while deselected");

  chk_miso_select: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    !miso_oe_n_o |-> !ss_n_i && !master_select)
    else $error("MISO driven while slave not selected");

  chk_ss_output_plain: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    (en_m && pdir[`SPMS_PDIR_SS] && !ss_n_i && !wr_ctrl)
    |=> master_select)
    else $error("select output pin disturbed master mode");

  chk_mode_fault: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    mode_fault |=> !master_select && sck_oe_n_o && mosi_oe_n_o
                   && (state == SPMS_IDLE))
    else $error("mode fault did not release master");

  chk_fault_flag: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    (mode_fault && irq_en && global_irq_en_i && !wr_ctrl) |=> tcf && irq_o)
    else $error("mode fault did not raise completion flag");

  chk_irq_gate: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    irq_o |-> tcf && irq_en && $past(xfer_end || mode_fault || tcf))
    else $error("interrupt without a completion flag");

  chk_disabled_idle: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    (!port_en && !wr_ctrl) |=> (state == SPMS_IDLE) && (bit_cnt == 3'h0))
    else $error("transfer while port disabled");

  chk_sck_idle: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    ($past(state) != SPMS_SHIFT && state != SPMS_SHIFT && $stable(clock_idle_level))
    |-> sck_o == clock_idle_level)
    else $error("SCK not at idle level");

  chk_fast_rate: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    (state == SPMS_SHIFT && $past(state) == SPMS_SHIFT && double_rate
     && rate == 2'h0 && $stable(rate)) |-> sck_o != $past(sck_o))
    else $error("fastest rate not two clocks per period");

  chk_byte_done: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    (master_end && !mode_fault)
    |=> tcf && (state == SPMS_DONE) && (sck_o == $past(clock_idle_level)))
    else $error("master byte end not flagged");

  chk_collision: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    (wr_data && state == SPMS_SHIFT && !master_end && en_m && !mode_fault)
    |=> write_collision_flag && (state == SPMS_SHIFT))
    else $error("write during transfer not flagged");

  chk_flag_clear: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    (data_acc && arm_tcf && !xfer_end && !mode_fault) |=> !tcf)
    else $error("completion flag not cleared");

  chk_reserved_zero: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    $past(rd_stat) |-> reg_rdata_o[5:1] == 5'h00)
    else $error("reserved status bits not zero");

  chk_data_read: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    rd_data |=> reg_rdata_o == $past(rx_buf))
    else $error("data read not from receive buffer");
endmodule : spms_top

//--- spms_defs.svh
// Offsets, field positions, reset values and counts of the serial port.
// Assumes inclusion by bare name from the package and the top module.
`ifndef SPMS_DEFS_SVH
`define SPMS_DEFS_SVH
// ****************************************
// Register offsets
// ****************************************
`define SPMS_OFF_CTRL    3'h0
`define SPMS_OFF_STAT    3'h1
`define SPMS_OFF_DATA    3'h2
`define SPMS_OFF_PDIR    3'h3
// ****************************************
// Field positions
// ****************************************
`define SPMS_CTRL_IRQEN  7
`define SPMS_CTRL_EN     6
`define SPMS_CTRL_LSBF   5
`define SPMS_CTRL_MASTER_SELECT   4
`define SPMS_CTRL_CLOCK_IDLE_LEVEL   3
`define SPMS_CTRL_CLOCK_EDGE_PHASE   2
`define SPMS_CTRL_RATE_H 1
`define SPMS_CTRL_RATE_L 0
`define SPMS_STAT_TCF    7
`define SPMS_STAT_WRITE_COLLISION_FLAG   6
`define SPMS_STAT_DBL    0
`define SPMS_PDIR_MOSI   0
`define SPMS_PDIR_MISO   1
`define SPMS_PDIR_SCK    2
`define SPMS_PDIR_SS     3
`define SPMS_PDIR_SSLVL  4
// ****************************************
// Reset values
// ****************************************
`define SPMS_RST_CTRL    8'h00
`define SPMS_RST_DATA    8'h00
`define SPMS_RST_PDIR    5'h00
`define SPMS_RST_SSLVL   1'b1
// ****************************************
// Counts: half SCK period minus one in clk_i cycles, then last edge count and last bit count
// ****************************************
`define SPMS_HALF_D4     6'h01
`define SPMS_HALF_D16    6'h07
`define SPMS_HALF_D64    6'h1f
`define SPMS_HALF_D128   6'h3f
`define SPMS_HALF_D2     6'h00
`define SPMS_HALF_D8     6'h03
`define SPMS_HALF_D32    6'h0f
`define SPMS_EDGES_LAST  4'hf
`define SPMS_BITS_LAST   3'h7
`endif

//--- spms_pkg.sv
// Types and rate decode of the serial port.
// Assumes spms_defs.svh is on the include path.
package spms_pkg;
`include "spms_defs.svh"

  typedef enum logic [1:0]
  {
    SPMS_IDLE  = 2'b00,
    SPMS_SHIFT = 2'b01,
    SPMS_DONE  = 2'b11
  } spms_state_t;

  typedef logic [5:0] spms_half_t;

  // Select is {double rate, rate high, rate low}
  function automatic spms_half_t spms_half_limit(input logic [2:0] sel);
    case (sel)
      3'h0:    return `SPMS_HALF_D4;
      3'h1:    return `SPMS_HALF_D16;
      3'h2:    return `SPMS_HALF_D64;
      3'h3:    return `SPMS_HALF_D128;
      3'h4:    return `SPMS_HALF_D2;
      3'h5:    return `SPMS_HALF_D8;
      3'h6:    return `SPMS_HALF_D32;
      default: return `SPMS_HALF_D64;
    endcase
  endfunction : spms_half_limit
endpackage : spms_pkg

//--- spms_edge_if.sv
// Carrier between the SCK edge detector and the port core.
// Assumes both ends run on the same clk_i.
`timescale 1ns/10ps
interface spms_edge_if;
  logic sck;
  logic clock_idle_level;
  logic lead;
  logic trail;
  modport det (input sck, input clock_idle_level, output lead, output trail);
  modport usr (output sck, output clock_idle_level, input lead, input trail);
endinterface : spms_edge_if

//--- spms_edge_det.sv
// Leading and trailing edge detector for an incoming SCK.
// Assumes SCK is synchronous to clk_i.
`timescale 1ns/10ps
module spms_edge_det
(
  input wire         clk_i,
  input wire         arst_n_i,
  spms_edge_if.det   eif
);
  logic sck_q;

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      sck_q <= 1'b0;
    else
      sck_q <= eif.sck;
  end

  // Leading edge leaves the idle level, trailing edge returns to it
  assign eif.lead  = (eif.sck != sck_q) && (eif.sck != eif.clock_idle_level);
  assign eif.trail = (eif.sck != sck_q) && (eif.sck == eif.clock_idle_level);
endmodule : spms_edge_det

//--- spms_rate_div.sv
// Divider that pulses once per half SCK period while running.
// Assumes limit_i is stable during a transfer.
`timescale 1ns/10ps
module spms_rate_div
#(
  parameter int CNT_W = 6
)
(
  input  wire logic             clk_i,
  input  wire logic             arst_n_i,
  input  wire logic             run_i,
  input  wire logic [CNT_W-1:0] limit_i,
  output logic                  tick_o
);
  logic [CNT_W-1:0] cnt;

  if (CNT_W < 6)
  begin : g_bad_width
    $error("spms_rate_div: CNT_W must be at least 6");
  end

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      cnt <= '0;
    else if (!run_i || (cnt == limit_i))
      cnt <= '0;
    else
      cnt <= cnt + 1'b1;
  end

  assign tick_o = run_i && (cnt == limit_i);
endmodule : spms_rate_div

//--- spms_peer.sv
// SPI slave peer facing the port while it runs as master.
// Assumes mode inputs change only while the peer is deselected.
`timescale 1ns/10ps
module spms_peer
(
  input  wire logic       sck_i,
  input  wire logic       mosi_i,
  input  wire logic       ss_n_i,
  input  wire logic       clock_idle_level_i,
  input  wire logic       clock_edge_phase_i,
  input  wire logic       lsb_i,
  input  wire logic [7:0] tx_i,
  output logic            miso_o,
  output logic      [7:0] rx_o
);
  int unsigned cnt;
  function automatic logic pick(input int unsigned k);
    return lsb_i ? tx_i[k] : tx_i[7-k];
  endfunction : pick
  // Released line flips away from its last level
  always @(ss_n_i)
  begin
    cnt = 0;
    miso_o = ss_n_i ? (miso_o !== 1'b1) : pick(0);
  end
  always @(sck_i)
  begin
    if (!ss_n_i && sck_i === ~(clock_idle_level_i ^ clock_edge_phase_i))
    begin
      if (cnt < 8)
        rx_o = lsb_i ? {mosi_i, rx_o[7:1]} : {rx_o[6:0], mosi_i};
      cnt++;
    end
    else if (!ss_n_i && cnt < 8)
      miso_o = pick(cnt);
  end
endmodule : spms_peer

//--- spms_top_tb_top.sv
// Self-checking bench: port as master against a peer, then hand tests.
// Assumes the package, interface and design modules are compiled first.
`timescale 1ns/10ps
`include "spms_defs.svh"
module spms_top_tb_top;
`define CHK(nm, e, g) \
  begin \
    total_checks++; \
    if ((g) !== (e)) \
    begin \
      miscompares++; \
      $display("ERROR %s expected %h seen %h", nm, e, g); \
    end \
  end
  typedef struct packed
  {
    logic [7:0] ctrl;
    logic       dbl;
    logic [7:0] tx;
    logic [7:0] ptx;
    int         div;
  } spms_row_t;
  localparam spms_row_t rows [8] = '{
    '{8'hd0, 1'b0, 8'h96, 8'h3a, 4}, '{8'hf5, 1'b0, 8'hc1, 8'h7e, 16},
    '{8'hda, 1'b0, 8'h2d, 8'he4, 64}, '{8'hff, 1'b0, 8'hb8, 8'h15, 128},
    '{8'hd0, 1'b1, 8'h4f, 8'ha3, 2}, '{8'hf5, 1'b1, 8'he2, 8'h59, 8},
    '{8'hda, 1'b1, 8'h71, 8'h8c, 32}, '{8'hff, 1'b1, 8'h0b, 8'hd6, 64}};
  logic       clk_i = 1'b0;
  logic       arst_n_i = 1'b0;
  logic       reg_we_i = 1'b0;
  logic       reg_re_i = 1'b0;
  logic [2:0] reg_addr_i = 3'h0;
  logic [7:0] reg_wdata_i = 8'h00;
  logic       gie = 1'b1;
  logic       ack = 1'b0;
  logic       ss_drv = 1'b1;
  logic       clock_idle_level = 1'b0;
  logic       clock_edge_phase = 1'b0;
  logic       lsb = 1'b0;
  logic [7:0] ptx = 8'h00;
  logic [7:0] reg_rdata_o, prx, v, sv;
  logic       xsck = 1'b0, xmosi = 1'b0;
  logic       irq_o, sck_o, sck_oe_n_o, mosi_o, mosi_oe_n_o, pmiso;
  logic       miso_o, miso_oe_n_o, ss_n_o, ss_oe_n_o;
  logic       sck_w, mosi_w, miso_w, ss_w;
  int         miscompares = 0;
  int         total_checks = 0;
  int         n;
  assign sck_w  = sck_oe_n_o ? xsck : sck_o;
  assign mosi_w = mosi_oe_n_o ? xmosi : mosi_o;
  assign miso_w = miso_oe_n_o ? pmiso : miso_o;
  assign ss_w   = ss_oe_n_o ? ss_drv : ss_n_o;
  spms_top dut_u (.clk_i(clk_i), .arst_n_i(arst_n_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_we_i(reg_we_i), .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o),
    .global_irq_en_i(gie), .irq_ack_i(ack), .irq_o(irq_o),
    .sck_i(sck_w), .sck_o(sck_o), .sck_oe_n_o(sck_oe_n_o),
    .mosi_i(mosi_w), .mosi_o(mosi_o), .mosi_oe_n_o(mosi_oe_n_o),
    .miso_i(miso_w), .miso_o(miso_o), .miso_oe_n_o(miso_oe_n_o),
    .ss_n_i(ss_w), .ss_n_o(ss_n_o), .ss_oe_n_o(ss_oe_n_o));
  spms_peer peer_u (.sck_i(sck_w), .mosi_i(mosi_w), .ss_n_i(ss_w),
    .clock_idle_level_i(clock_idle_level), .clock_edge_phase_i(clock_edge_phase), .lsb_i(lsb), .tx_i(ptx),
    .miso_o(pmiso), .rx_o(prx));
  initial
  begin
    forever #25 clk_i = ~clk_i;
  end
  // ****************************************
  // Bus tasks and closing report
  // ****************************************
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_i);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_we_i    <= 1'b1;
    @(posedge clk_i);
    reg_we_i    <= 1'b0;
  endtask : wr
  task automatic rd(input logic [2:0] a);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_re_i   <= 1'b1;
    @(posedge clk_i);
    reg_re_i   <= 1'b0;
    @(negedge clk_i);
    v = reg_rdata_o;
  endtask : rd
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : give_verdict
  task automatic wait_irq(input int lim);
    n = 0;
    while (irq_o !== 1'b1 && n < lim)
    begin
      @(negedge clk_i);
      n++;
    end
    if (irq_o !== 1'b1)
    begin
      miscompares++;
      give_verdict();
    end
  endtask : wait_irq
  task automatic do_reset();
    @(posedge clk_i);
    arst_n_i <= 1'b0;
    repeat (12) @(posedge clk_i);
    arst_n_i <= 1'b1;
  endtask : do_reset
  task automatic sclk(input int nb, input logic [7:0] d);
    for (int k = 0; k < nb; k++)
    begin
      @(posedge clk_i);
      xmosi <= d[7-k];
      repeat (3) @(posedge clk_i);
      xsck  <= 1'b1;
      sv    <= {sv[6:0], miso_w};
      repeat (3) @(posedge clk_i);
      xsck  <= 1'b0;
    end
  endtask : sclk
  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    do_reset();
    foreach (rows[i])
    begin
      wr(`SPMS_OFF_PDIR, 8'h1d);
      clock_idle_level = rows[i].ctrl[3];
      clock_edge_phase = rows[i].ctrl[2];
      lsb  = rows[i].ctrl[5];
      ptx  = rows[i].ptx;
      wr(`SPMS_OFF_CTRL, rows[i].ctrl);
      wr(`SPMS_OFF_STAT, {7'h00, rows[i].dbl});
      wr(`SPMS_OFF_PDIR, 8'h0d);
      wr(`SPMS_OFF_DATA, rows[i].tx);
      wait_irq(3000);
      `CHK("byte_time", 1'b1, n >= 8*rows[i].div-1 && n <= 8*rows[i].div+2);
      `CHK("sck_idle", clock_idle_level, sck_o);
      `CHK("peer_rx", rows[i].tx, prx);
      rd(`SPMS_OFF_STAT);
      `CHK("status", {1'b1, 6'h00, rows[i].dbl}, v);
      rd(`SPMS_OFF_DATA);
      `CHK("rx_data", rows[i].ptx, v);
      `CHK("irq_clr", 1'b0, irq_o);
      $display("row %0d done", i);
    end
    do_reset();
    `CHK("ss_level", 1'b1, ss_n_o);
    rd(`SPMS_OFF_CTRL);
    `CHK("ctrl_rst", 8'h00, v);
    wr(`SPMS_OFF_STAT, 8'hff);
    rd(`SPMS_OFF_STAT);
    `CHK("stat_ro", 8'h01, v);
    rd(3'h5);
    `CHK("unmapped", 8'h00, v);
    $display("reset test done");
    clock_idle_level = 1'b0;
    clock_edge_phase = 1'b0;
    lsb  = 1'b0;
    ptx  = 8'h69;
    wr(`SPMS_OFF_CTRL, 8'hd0);
    wr(`SPMS_OFF_PDIR, 8'h0d);
    wr(`SPMS_OFF_DATA, 8'ha5);
    wr(`SPMS_OFF_DATA, 8'h5a);
    wait_irq(100);
    `CHK("no_restart", 8'ha5, prx);
    rd(`SPMS_OFF_STAT);
    `CHK("stat_write_collision_flag", 8'hc1, v);
    rd(`SPMS_OFF_DATA);
    `CHK("rx_kept", 8'h69, v);
    rd(`SPMS_OFF_STAT);
    `CHK("stat_clr", 8'h01, v);
    $display("collision test done");
    wr(`SPMS_OFF_PDIR, 8'h05);
    ss_drv <= 1'b0;
    repeat (4) @(negedge clk_i);
    `CHK("sck_rel", 1'b1, sck_oe_n_o);
    `CHK("mosi_rel", 1'b1, mosi_oe_n_o);
    `CHK("irq_fault", 1'b1, irq_o);
    rd(`SPMS_OFF_CTRL);
    `CHK("master_select_clr", 8'hc0, v);
    rd(`SPMS_OFF_STAT);
    `CHK("tcf_fault", 8'h81, v);
    @(posedge clk_i);
    gie <= 1'b0;
    @(negedge clk_i);
    `CHK("irq_gated", 1'b0, irq_o);
    @(posedge clk_i);
    gie <= 1'b1;
    @(negedge clk_i);
    `CHK("irq_on", 1'b1, irq_o);
    @(posedge clk_i);
    ack <= 1'b1;
    @(posedge clk_i);
    ack <= 1'b0;
    @(negedge clk_i);
    `CHK("irq_ack", 1'b0, irq_o);
    @(posedge clk_i);
    ss_drv <= 1'b1;
    wr(`SPMS_OFF_CTRL, 8'hd0);
    rd(`SPMS_OFF_CTRL);
    `CHK("master_select_back", 8'hd0, v);
    $display("mode fault test done");
    wr(`SPMS_OFF_CTRL, 8'h90);
    wr(`SPMS_OFF_PDIR, 8'h0d);
    wr(`SPMS_OFF_DATA, 8'h33);
    repeat (40) @(negedge clk_i);
    `CHK("no_xfer", 1'b0, irq_o);
    `CHK("no_sck", 1'b1, sck_oe_n_o);
    $display("disable test done");
    wr(`SPMS_OFF_PDIR, 8'h02);
    wr(`SPMS_OFF_CTRL, 8'h40);
    wr(`SPMS_OFF_DATA, 8'hc3);
    sclk(8, 8'hff);
    `CHK("miso_off", 1'b1, miso_oe_n_o);
    rd(`SPMS_OFF_STAT);
    `CHK("slv_passive", 8'h01, v);
    @(posedge clk_i);
    ss_drv <= 1'b0;
    sclk(8, 8'h5c);
    `CHK("slv_tx", 8'hc3, sv);
    rd(`SPMS_OFF_STAT);
    `CHK("slv_done", 8'h81, v);
    rd(`SPMS_OFF_DATA);
    `CHK("slv_rx", 8'h5c, v);
    sclk(3, 8'hff);
    @(posedge clk_i);
    ss_drv <= 1'b1;
    @(posedge clk_i);
    ss_drv <= 1'b0;
    sclk(8, 8'h96);
    rd(`SPMS_OFF_DATA);
    `CHK("slv_drop", 8'h96, v);
    $display("slave test done");
    give_verdict();
  end
endmodule : spms_top_tb_top
